// ### async_serial_transmitter.v
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "async_serial_transmitter_defines.vh"

// Notes on behaviour
// - length select picks 8 or 9 bits
// - shift register drives line; buffer holds byte
// - dma write alone clears buffer-free flag
// - preamble of ones precedes first character
// - start zero at lsb, stop one msb
// - buffer transfer sets buffer-free flag
// - buffer irq or dma request, dma suppresses cpu
// - line idles high when not shifting
// - unit off releases port pins
// - break characters repeat while break set
// - break ends with at least one one
// - receiver detects all-zero frame as break
// - break sets fault, full, seen; clears data
// - idle character all ones, length follows select
// - tx off finishes character then idles
// - tx off-on queues one idle character
// - polarity flip inverts every transmitted level
// - shift done when all empty, irq gated
// - rx ninth bit holds bit 8 or 7
module async_serial_transmitter (
    input  wire       I_CLK_SYS,      // system clock, 40 MHz
    input  wire       I_RESET_N,      // synchronous reset, active low
    input  wire [7:0] I_ADDR,         // register address
    input  wire [7:0] I_WDATA,        // write data
    input  wire       I_WR,           // write strobe
    input  wire       I_RD,           // read strobe
    input  wire       I_DMA_WR,       // write strobe is from dma engine
    input  wire       I_BIT_TICK,     // one pulse per bit time
    input  wire       I_RX_BIT,       // receiver sampled bit
    input  wire       I_RX_BIT_VALID, // pulse per received frame bit
    output reg  [7:0] O_RDATA,        // read data, cycle after read
    output reg        O_TX_LINE,      // tx_line_pin level
    output reg        O_TX_LINE_OE,   // high while driving the pin
    output reg        O_TX_IRQ,       // transmitter cpu request
    output reg        O_TX_DMA_REQ    // transmitter dma request
);
    reg [7:0] ctl1_q;
    reg [7:0] ctl2_q;
    reg [7:0] ctl3_q;
    reg [7:0] rate_q;
    reg [7:0] buf_q;
    reg       buf_full_q;
    reg       buf_free_q;
    reg       done_q;
    reg       armed_q;
    reg [1:0] state_q;
    reg [10:0] shreg_q;
    reg [3:0] bits_q;
    reg       idle_q;
    reg       tx_on_last_q;
    reg       idle_pend_q;
    reg       brk_tail_q;
    reg [7:0] rx_data_q;
    reg       rx_ninth_q;
    reg       rx_full_q;
    reg       rx_fault_q;
    reg       brk_seen_q;
    reg       rx_prog_q;
    reg [3:0] rx_cnt_q;
    reg [10:0] rx_sh_q;
    // decoded control bits and shared strobes
    // unit_on gates the bit tick, so a disabled unit never advances a frame
    // frame_len counts every bit time of a character, framing included
    // a data write is seen on the plain bus strobe, dma or cpu alike
    // last_bit marks the final bit time of the slot being shifted
    // slot_end is true between frames or on the closing tick of one
    // a new slot may only begin at slot_end, which keeps bit times whole
    // tx_fall catches tx_on being dropped, for the queued idle character
    // load_char is the one moment the holding stage empties into the shifter
    // a stalled preamble never loads, so an off tx keeps the byte buffered
    wire       unit_on   = ctl1_q[`C1_SERIAL_UNIT_ON];
    wire       len9      = ctl1_q[`C1_LEN9];
    wire       tx_on     = ctl2_q[`C2_TX_ON];
    wire       send_brk  = ctl2_q[`C2_SEND_BREAK];
    wire [3:0] frame_len = len9 ? `FRAME_BITS_9 : `FRAME_BITS_8;
    wire       bus_wr_dat = I_WR && (I_ADDR == `ADDR_DATA_BUFFER);
    wire       tick       = I_BIT_TICK && unit_on;
    wire       last_bit   = (bits_q == 4'h1);
    wire       shifting   = (state_q != `ST_IDLE);
    // a character slot has ended and a new one may be loaded
    wire       slot_end   = !shifting || (tick && last_bit);
    wire       tx_fall    = tx_on_last_q && !tx_on;
    // transfer the buffered byte into the shifter
    wire       load_char  = slot_end && tick && tx_on && buf_full_q && !send_brk
                            && !idle_pend_q && !brk_tail_q && (state_q != `ST_IDLE
                            || armed_q);
    // receiver frame complete on the bit that lands in the stop position
    // the stop bit itself is judged live, before it enters the shifter
    wire       rx_done    = I_RX_BIT_VALID && unit_on && ctl2_q[`C2_RX_ON]
                            && (rx_cnt_q == frame_len - 4'h1);
    wire [7:0] status_one = {buf_free_q, done_q, rx_full_q, 3'h0, rx_fault_q, 1'h0};

    // register writes; reset clears all control
    // writes take effect on the edge that samples the strobe
    // control_three bit 7 is the received ninth bit and stays read-only
    // the data buffer is handled by the holding stage, not here
    // status registers have no write side; such writes fall through
    // bit_rate_select is only stored: the tick comes from a shared divider
    // limitation: unmapped writes are silently dropped
    // trade-off: no write masking, software must write whole bytes
    // unused control bits are kept so read-back matches what was written
    // a write and a read of one register may follow with no gap
    always @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            ctl1_q <= `RST_BYTE;
            ctl2_q <= `RST_BYTE;
            ctl3_q <= `RST_BYTE;
            rate_q <= `RST_BYTE;
        end else if (I_WR) begin
            case (I_ADDR)
                `ADDR_CONTROL_ONE:   ctl1_q <= I_WDATA;
                `ADDR_CONTROL_TWO:   ctl2_q <= I_WDATA;
                `ADDR_CONTROL_THREE: ctl3_q <= {ctl3_q[7], I_WDATA[6:0]}; // rx ninth is RO
                `ADDR_BIT_RATE_SEL:  rate_q <= I_WDATA;
                default:             ctl1_q <= ctl1_q;
            endcase
        end
    end

    // read mux, answer in the following cycle; unmapped reads zero
    // read data stand for one cycle only and are zero otherwise
    // zero outside a read slot lets a bus or-tree merge several slaves
    // control_three merges the received ninth bit into bit 7
    // status_two carries only break seen and reception in progress
    // the data offset reads the receive side; transmit is write-only
    // reading status_one also arms the buffer-free clear, see below
    // reading the data buffer clears the receive flags, see below
    // no wait states: the master never stalls
    // limitation: reads have no side effect on this mux itself
    always @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            O_RDATA <= `RST_BYTE;
        end else if (I_RD) begin
            case (I_ADDR)
                `ADDR_CONTROL_ONE:   O_RDATA <= ctl1_q;
                `ADDR_CONTROL_TWO:   O_RDATA <= ctl2_q;
                `ADDR_CONTROL_THREE: O_RDATA <= {rx_ninth_q, ctl3_q[6:0]};
                `ADDR_STATUS_ONE:    O_RDATA <= status_one;
                `ADDR_STATUS_TWO:    O_RDATA <= {6'h00, brk_seen_q, rx_prog_q};
                `ADDR_DATA_BUFFER:   O_RDATA <= rx_data_q; // tx side is write-only
                `ADDR_BIT_RATE_SEL:  O_RDATA <= rate_q;
                default:             O_RDATA <= `RST_BYTE;
            endcase
        end else begin
            O_RDATA <= `RST_BYTE;
        end
    end

    // holding stage and its free flag; the transfer set wins over a same-cycle write
    // armed_q remembers a status read seen with the free flag set
    // a cpu write clears the flag only once armed; a dma write always does
    // a write without the prior read still fills the buffer but leaves free set
    // hazard: losing the set to a same-cycle write would hang the producer
    // buf_full_q tracks real contents, independent of the software flag
    // a write in the load cycle refills the stage at once
    // the free flag also feeds the transmitter requests at the pins
    // reset leaves the stage empty and free, so software may write at once
    // trade-off: one holding byte only, no deeper queue
    always @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            buf_q      <= `RST_BYTE;
            buf_full_q <= 1'b0;
            buf_free_q <= 1'b1;
            armed_q    <= 1'b0;
        end else begin
            if (I_RD && I_ADDR == `ADDR_STATUS_ONE && buf_free_q)
                armed_q <= 1'b1;
            if (bus_wr_dat) begin
                buf_q      <= I_WDATA;
                buf_full_q <= 1'b1;
                if (armed_q || I_DMA_WR) begin
                    buf_free_q <= 1'b0;
                    armed_q    <= 1'b0;
                end
            end
            if (load_char) begin
                buf_full_q <= bus_wr_dat;
                buf_free_q <= 1'b1;
            end
        end
    end

    // transmit sequencer: preamble, characters, breaks, idles
    // idle_q is the line level before polarity, updated on the tick
    // the shifter fills with ones from the top, so a drained slot idles high
    // every slot lasts frame_len ticks except the one-bit break tail
    // priority at a slot end: break, break tail, idle, character, idle line
    // a break repeats while the break bit stays set
    // the break tail guarantees a one before the next start bit
    // a transmission opens with a preamble, an idle character of ones
    // the ninth bit is read from control_three at the load, so writes after the load miss the frame
    // clearing tx_on lets the slot in flight finish, then the line idles
    // clearing the unit aborts at once and returns the sequencer to idle; the holding stage keeps its byte
    always @(posedge I_CLK_SYS) begin
        if (!I_RESET_N || !unit_on) begin
            state_q      <= `ST_IDLE;
            shreg_q      <= 11'h7FF;
            bits_q       <= 4'h0;
            idle_q       <= 1'b1;
            tx_on_last_q <= 1'b0;
            idle_pend_q  <= 1'b0;
            brk_tail_q   <= 1'b0;
        end else begin
            tx_on_last_q <= tx_on;
            // off then on while shifting queues one idle character
            if (tx_fall && shifting)
                idle_pend_q <= 1'b1;
            if (tick && shifting && !last_bit) begin
                shreg_q <= {1'b1, shreg_q[10:1]};
                bits_q  <= bits_q - 4'h1;
                idle_q  <= shreg_q[1];
            end else if (slot_end && tick) begin
                if (send_brk && (tx_on || state_q == `ST_BREAK)) begin
                    state_q    <= `ST_BREAK;
                    shreg_q    <= 11'h000;
                    bits_q     <= frame_len;
                    idle_q     <= 1'b0;
                    brk_tail_q <= 1'b1;
                end else if (brk_tail_q) begin
                    state_q    <= `ST_PREAMBLE;
                    shreg_q    <= 11'h7FF;
                    bits_q     <= 4'h1;
                    idle_q     <= 1'b1;
                    brk_tail_q <= 1'b0;
                end else if (tx_on && (idle_pend_q || (state_q == `ST_IDLE
                             && buf_full_q && armed_q == 1'b0 && !buf_free_q))) begin
                    state_q     <= `ST_PREAMBLE;
                    shreg_q     <= 11'h7FF;
                    bits_q      <= frame_len;
                    idle_q      <= 1'b1;
                    idle_pend_q <= 1'b0;
                end else if (load_char || (tx_on && buf_full_q && !buf_free_q
                             && state_q == `ST_PREAMBLE)) begin
                    state_q <= `ST_SHIFT;
                    shreg_q <= len9 ? {1'b1, ctl3_q[`C3_TX_NINTH], buf_q, 1'b0}
                                    : {2'b11, buf_q, 1'b0};
                    bits_q  <= frame_len;
                    idle_q  <= 1'b0;
                end else begin
                    state_q <= `ST_IDLE;
                    shreg_q <= 11'h7FF;
                    bits_q  <= 4'h0;
                    idle_q  <= 1'b1;
                end
            end
        end
    end

    // shift done: nothing queued, nothing shifting
    // registered, so it trails the sequencer by one cycle
    // a pending break or queued idle keeps it low
    // reset sets it: an empty transmitter has nothing outstanding
    // limitation: it clears by itself, software has no clear path
    always @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            done_q <= 1'b1;
        end else begin
            done_q <= !shifting && !buf_full_q && !send_brk && !idle_pend_q;
        end
    end

    // pin and requests, all registered
    // polarity flip applies last, so idle, break and framing all invert
    // the pin enable follows the unit bit one cycle late
    // the dma request takes the buffer request away from the cpu
    // the shift-done request always goes to the cpu
    // registering every output keeps the pins glitch free
    // trade-off: each request lags its flag by one cycle
    // requests are levels and fall when their flag clears
    always @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            O_TX_LINE    <= 1'b1;
            O_TX_LINE_OE <= 1'b0;
            O_TX_IRQ     <= 1'b0;
            O_TX_DMA_REQ <= 1'b0;
        end else begin
            O_TX_LINE    <= idle_q ^ ctl1_q[`C1_TX_POLARITY];
            O_TX_LINE_OE <= unit_on;
            // dma takes the request away from the cpu
            O_TX_DMA_REQ <= buf_free_q && ctl2_q[`C2_TX_BUF_IRQ_ON] && ctl3_q[`C3_TX_DMA_ON];
            O_TX_IRQ     <= (buf_free_q && ctl2_q[`C2_TX_BUF_IRQ_ON]
                             && !ctl3_q[`C3_TX_DMA_ON])
                            || (done_q && ctl2_q[`C2_SHIFT_DONE_IRQ]);
        end
    end

    // minimal frame assembler for break recognition
    // bits arrive already sampled, start bit first, one strobe each
    // the count wraps at frame_len so frames stay aligned
    // a zero stop bit marks a framing fault
    // all-zero data with a zero stop is a break: data and ninth bit clear
    // with a one stop bit the data byte and ninth bit are stored
    // in 8-bit mode the ninth bit copies received bit 7
    // a data buffer read clears full, fault and break seen
    // limitation: no noise, parity or overrun detection here
    // the receive flags clear on reset and data buffer reads, not on unit off
    always @(posedge I_CLK_SYS) begin
        if (!I_RESET_N) begin
            rx_data_q  <= `RST_BYTE;
            rx_ninth_q <= 1'b0;
            rx_full_q  <= 1'b0;
            rx_fault_q <= 1'b0;
            brk_seen_q <= 1'b0;
            rx_prog_q  <= 1'b0;
            rx_cnt_q   <= 4'h0;
            rx_sh_q    <= 11'h000;
        end else begin
            if (I_RD && I_ADDR == `ADDR_DATA_BUFFER) begin
                rx_full_q  <= 1'b0;
                rx_fault_q <= 1'b0;
                brk_seen_q <= 1'b0;
            end
            if (I_RX_BIT_VALID && unit_on && ctl2_q[`C2_RX_ON]) begin
                rx_sh_q   <= {I_RX_BIT, rx_sh_q[10:1]};
                rx_prog_q <= !rx_done;
                rx_cnt_q  <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
            end
            if (rx_done) begin
                rx_full_q <= 1'b1;
                if (!I_RX_BIT) begin
                    rx_fault_q <= 1'b1;
                    if (!len9 ? rx_sh_q[10:3] == 8'h00 : rx_sh_q[10:2] == 9'h000) begin
                        brk_seen_q <= 1'b1;
                        rx_data_q  <= 8'h00;
                        rx_ninth_q <= 1'b0;
                    end
                end else begin
                    rx_data_q  <= len9 ? rx_sh_q[9:2] : rx_sh_q[10:3];
                    rx_ninth_q <= len9 ? rx_sh_q[10] : rx_sh_q[10];
                end
            end
        end
    end
endmodule

// ### async_serial_transmitter_asserts.sv
`timescale 1ns/1ps
module async_serial_transmitter_checker (
    input wire       I_CLK_SYS,
    input wire       I_RESET_N,
    input wire [7:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire       I_WR,
    input wire       I_RD,
    input wire       I_DMA_WR,
    input wire       I_BIT_TICK,
    input wire       I_RX_BIT,
    input wire       I_RX_BIT_VALID,
    input wire [7:0] O_RDATA,
    input wire       O_TX_LINE,
    input wire       O_TX_LINE_OE,
    input wire       O_TX_IRQ,
    input wire       O_TX_DMA_REQ
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESET_N);
    // decode helpers kept as wires so $past sees plain signals
    wire unit_bit = I_WDATA[6];
    wire map_hit  = (I_ADDR >= 8'h13) && (I_ADDR <= 8'h19);
    wire tick_or_wr = I_BIT_TICK || I_WR;

    reset_values_a: assert property ($rose(I_RESET_N) |-> O_TX_LINE && !O_TX_LINE_OE
        && !O_TX_IRQ && !O_TX_DMA_REQ) else $error("outputs not idle after reset");
    oe_follows_unit_a: assert property (I_WR && I_ADDR == 8'h13
        |=> ##1 O_TX_LINE_OE == $past(unit_bit, 2)) else $error("pin enable wrong");
    read_idle_zero_a: assert property (!I_RD |=> O_RDATA == 8'h00)
        else $error("read data outside read slot");
    unmapped_zero_a: assert property (I_RD && !map_hit |=> O_RDATA == 8'h00)
        else $error("unmapped read not zero");
    req_exclusive_a: assert property (!(O_TX_IRQ && O_TX_DMA_REQ))
        else $error("cpu and dma requests together");
    // line moves only on bit time or after a control write such as polarity
    line_on_tick_a: assert property ($changed(O_TX_LINE)
        |-> $past(tick_or_wr, 1) || $past(tick_or_wr, 2)) else $error("line moved off tick");
    dma_write_clears_a: assert property (I_WR && I_DMA_WR && I_ADDR == 8'h18
        |-> ##[1:3] !O_TX_DMA_REQ) else $error("dma write kept request");
    free_flag_read_a: assert property (I_RD && I_ADDR == 8'h16 && O_TX_DMA_REQ
        |=> O_RDATA[7]) else $error("request without buffer free");
    cover property ($rose(O_TX_DMA_REQ));
    cover property ($fell(O_TX_LINE));
    cover property ($rose(O_TX_IRQ));
endmodule
bind async_serial_transmitter async_serial_transmitter_checker async_serial_transmitter_checker_inst (
    .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .I_DMA_WR(I_DMA_WR), .I_BIT_TICK(I_BIT_TICK),
    .I_RX_BIT(I_RX_BIT), .I_RX_BIT_VALID(I_RX_BIT_VALID), .O_RDATA(O_RDATA),
    .O_TX_LINE(O_TX_LINE), .O_TX_LINE_OE(O_TX_LINE_OE), .O_TX_IRQ(O_TX_IRQ),
    .O_TX_DMA_REQ(O_TX_DMA_REQ));

// ### async_serial_transmitter_defines.vh
`ifndef ASYNC_SERIAL_TRANSMITTER_DEFINES_VH
`define ASYNC_SERIAL_TRANSMITTER_DEFINES_VH
// register offsets (8-bit addresses)
`define ADDR_CONTROL_ONE   8'h13
`define ADDR_CONTROL_TWO   8'h14
`define ADDR_CONTROL_THREE 8'h15
`define ADDR_STATUS_ONE    8'h16
`define ADDR_STATUS_TWO    8'h17
`define ADDR_DATA_BUFFER   8'h18
`define ADDR_BIT_RATE_SEL  8'h19
// control_one fields
`define C1_SERIAL_UNIT_ON  6
`define C1_TX_POLARITY     5
`define C1_LEN9            4
// control_two fields
`define C2_TX_BUF_IRQ_ON   7
`define C2_SHIFT_DONE_IRQ  6
`define C2_TX_ON           3
`define C2_RX_ON           2
`define C2_SEND_BREAK      0
// control_three fields
`define C3_RX_NINTH        7
`define C3_TX_NINTH        6
`define C3_TX_DMA_ON       4
// status_one fields
`define S1_TX_BUF_FREE     7
`define S1_SHIFT_DONE      6
`define S1_RX_FULL         5
`define S1_FRAMING         1
// status_two fields
`define S2_BREAK_SEEN      1
`define S2_RX_IN_PROGRESS  0
// reset values
`define RST_BYTE           8'h00
`define RST_STATUS_ONE     8'hC0
// frame sizes in bit times (8-bit mode; 9-bit adds one)
`define FRAME_BITS_8       4'hA
`define FRAME_BITS_9       4'hB
// tx state codes
`define ST_IDLE            2'h0
`define ST_PREAMBLE        2'h1
`define ST_SHIFT           2'h2
`define ST_BREAK           2'h3
`endif

// ### remote_serial_receiver.sv
`timescale 1ns/1ps
module remote_serial_receiver (
    input  wire       i_clk,  // system clock
    input  wire       i_tick, // bit-time pulse
    input  wire       i_line, // line from transmitter
    input  wire       i_flip, // undo inversion
    input  wire       i_len9, // nine data bits
    output reg        o_got,  // one-cycle frame pulse
    output reg  [8:0] o_data  // received character
);
    integer   pos = 0;
    reg [8:0] sh  = 9'h000;
    wire      bv  = i_line ^ i_flip;
    // one sample per bit time; zero stop bit means break, dropped
    always @(posedge i_clk) begin
        o_got <= 1'b0;
        if (i_tick) begin
            if (pos == 0) begin
                pos <= (bv == 1'b0) ? 1 : 0;
            end else if (pos <= (i_len9 ? 9 : 8)) begin
                sh[pos - 1] <= bv;
                pos <= pos + 1;
            end else begin
                o_got <= bv;
                o_data <= i_len9 ? sh : {1'b0, sh[7:0]};
                pos <= 0;
            end
        end
    end
endmodule

// ### test_async_serial_transmitter.sv
`timescale 1ns/1ps
module test_async_serial_transmitter;
    reg        I_CLK_SYS = 1'b0, I_RESET_N = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
    reg        I_DMA_WR = 1'b0, I_BIT_TICK = 1'b0, I_RX_BIT = 1'b0, I_RX_BIT_VALID = 1'b0;
    reg  [7:0] I_ADDR = 8'h00, I_WDATA = 8'h00, s = 8'h00, d;
    wire [7:0] O_RDATA;
    wire       O_TX_LINE, O_TX_LINE_OE, O_TX_IRQ, O_TX_DMA_REQ, got;
    wire [8:0] rxd;
    reg        flip = 1'b0, len9 = 1'b0;
    reg  [2:0] tcnt = 3'h0;
    reg  [8:0] expq[$];
    integer    fail_count = 0, n_checks = 0, i, j, k = 1;

    initial forever #12.5 I_CLK_SYS = ~I_CLK_SYS;
    // shared bit-rate tick, one in eight cycles keeps frames short
    always @(posedge I_CLK_SYS) begin
        tcnt <= tcnt + 3'h1;
        I_BIT_TICK <= (tcnt == 3'h7);
    end
    async_serial_transmitter async_serial_transmitter_inst (.I_CLK_SYS(I_CLK_SYS),
        .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
        .I_DMA_WR(I_DMA_WR), .I_BIT_TICK(I_BIT_TICK), .I_RX_BIT(I_RX_BIT),
        .I_RX_BIT_VALID(I_RX_BIT_VALID), .O_RDATA(O_RDATA), .O_TX_LINE(O_TX_LINE),
        .O_TX_LINE_OE(O_TX_LINE_OE), .O_TX_IRQ(O_TX_IRQ), .O_TX_DMA_REQ(O_TX_DMA_REQ));
    remote_serial_receiver remote_serial_receiver_inst (.i_clk(I_CLK_SYS), .i_tick(I_BIT_TICK),
        .i_line(O_TX_LINE), .i_flip(flip), .i_len9(len9), .o_got(got), .o_data(rxd));

    task chk(input [8:0] seen, input [8:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] v, input dma);
        @(posedge I_CLK_SYS);
        I_ADDR <= a;
        I_WDATA <= v;
        I_WR <= 1'b1;
        I_DMA_WR <= dma;
        @(posedge I_CLK_SYS);
        I_WR <= 1'b0;
        I_DMA_WR <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge I_CLK_SYS);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLK_SYS);
        I_RD <= 1'b0;
        #1 s = O_RDATA;
    endtask
    // status read then data write, polled with a bound
    task send(input [7:0] v);
        s = 8'h00;
        for (i = 0; i < 300 && s[7] !== 1'b1; i = i + 1) rd(8'h16);
        if (s[7] !== 1'b1) begin
            fail_count = fail_count + 1;
            summarize;
        end
        wr(8'h18, v, 1'b0);
        expq.push_back({len9, v});
    endtask
    task drain;
        for (i = 0; i < 4000 && expq.size() > 0; i = i + 1) @(posedge I_CLK_SYS);
        chk(expq.size(), 0);
        if (expq.size() != 0) summarize;
    endtask
    task wait_line(input v);
        for (i = 0; i < 800 && O_TX_LINE !== v; i = i + 1) @(posedge I_CLK_SYS);
        chk(O_TX_LINE, v);
        if (O_TX_LINE !== v) summarize;
    endtask
    // polarity moves just after a tick so the far end never sees a torn bit
    task set_one(input [7:0] v, input f);
        @(posedge I_CLK_SYS iff I_BIT_TICK === 1'b1);
        wr(8'h13, v, 1'b0);
        repeat (2) @(posedge I_CLK_SYS);
        flip <= f;
    endtask
    task done_t;
        $display("test %0d done", k);
        k = k + 1;
    endtask

    // oldest note against each character the far end frames
    always @(posedge I_CLK_SYS) if (got === 1'b1) begin
        if (expq.size() == 0) chk(rxd, ~rxd);
        else chk(rxd, expq.pop_front());
    end

    initial begin
        void'($urandom(10));
        repeat (10) @(posedge I_CLK_SYS);
        I_RESET_N <= 1'b1;
        chk(O_TX_LINE_OE, 0);
        chk(O_TX_LINE, 1);
        rd(8'h16);
        chk(s, 8'hC0);
        rd(8'h21);
        chk(s, 8'h00);
        done_t;
        set_one(8'h40, 1'b0);
        wr(8'h14, 8'h08, 1'b0);
        chk(O_TX_LINE_OE, 1);
        for (j = 0; j < 3; j = j + 1) send(8'($urandom));
        drain;
        chk(O_TX_LINE, 1);
        done_t;
        send(8'($urandom));
        wr(8'h14, 8'h00, 1'b0);
        wr(8'h14, 8'h08, 1'b0);
        send(8'($urandom));
        drain;
        send(8'($urandom));
        repeat (120) @(posedge I_CLK_SYS);
        wr(8'h14, 8'h00, 1'b0);
        drain;
        chk(O_TX_LINE, 1);
        wr(8'h14, 8'h08, 1'b0);
        done_t;
        wr(8'h15, 8'h40, 1'b0);
        len9 <= 1'b1;
        set_one(8'h70, 1'b1);
        for (j = 0; j < 2; j = j + 1) send(8'($urandom));
        drain;
        chk(O_TX_LINE, 0);
        done_t;
        wr(8'h15, 8'h00, 1'b0);
        len9 <= 1'b0;
        set_one(8'h40, 1'b0);
        wr(8'h14, 8'h09, 1'b0);
        wait_line(1'b0);
        for (j = 0; j < 20; j = j + 1) begin
            @(posedge I_CLK_SYS iff I_BIT_TICK === 1'b1);
            chk(O_TX_LINE, 0);
        end
        wr(8'h14, 8'h08, 1'b0);
        wait_line(1'b1);
        send(8'($urandom));
        drain;
        done_t;
        wr(8'h15, 8'h10, 1'b0);
        wr(8'h14, 8'h88, 1'b0);
        repeat (4) @(posedge I_CLK_SYS);
        chk(O_TX_DMA_REQ, 1);
        chk(O_TX_IRQ, 0);
        d = 8'($urandom);
        expq.push_back({1'b0, d});
        wr(8'h18, d, 1'b1);
        repeat (3) @(posedge I_CLK_SYS);
        chk(O_TX_DMA_REQ, 0);
        drain;
        wr(8'h15, 8'h00, 1'b0);
        repeat (4) @(posedge I_CLK_SYS);
        chk(O_TX_IRQ, 1);
        done_t;
        wr(8'h14, 8'h0C, 1'b0);
        for (j = 0; j < 10; j = j + 1) begin
            @(posedge I_CLK_SYS);
            I_RX_BIT_VALID <= 1'b1;
            @(posedge I_CLK_SYS);
            I_RX_BIT_VALID <= 1'b0;
        end
        repeat (2) @(posedge I_CLK_SYS);
        rd(8'h16);
        chk(s & 8'h22, 8'h22);
        rd(8'h17);
        chk(s[1], 1);
        rd(8'h18);
        chk(s, 8'h00);
        wr(8'h13, 8'h00, 1'b0);
        repeat (2) @(posedge I_CLK_SYS);
        chk(O_TX_LINE_OE, 0);
        done_t;
        summarize;
    end
endmodule
